/* File: rtl/perf_evt_params.svh */
// Event codes, unit-mask layouts and per-cycle limits for the core event sources.
`ifndef PERF_EVT_PARAMS_SVH
`define PERF_EVT_PARAMS_SVH

// ****************************************
// Event codes
// ****************************************
`define EVC_IC_FETCH 12'h080
`define EVC_IC_MISS 12'h081
`define EVC_IC_REFILL_L2 12'h082
`define EVC_IC_REFILL_SYS 12'h083
`define EVC_ITLB_L2_HIT 12'h084
`define EVC_ITLB_MISS 12'h085
`define EVC_PROBE_RESTART 12'h086
`define EVC_FETCH_STALL 12'h087
`define EVC_RS_HIT 12'h088
`define EVC_RS_OVERFLOW 12'h089
`define EVC_IC_VICTIM 12'h08b
`define EVC_IC_INVAL 12'h08c
`define EVC_ITLB_RELOAD 12'h099
`define EVC_ITLB_ABORT 12'h09a
`define EVC_DISPATCH 12'h186
`define EVC_RET_INSN 12'h0c0
`define EVC_RET_UOP 12'h0c1
`define EVC_RET_BRANCH 12'h0c2
`define EVC_RET_BR_MISP 12'h0c3
`define EVC_RET_TAKEN 12'h0c4
`define EVC_RET_TAKEN_MISP 12'h0c5
`define EVC_RET_FAR 12'h0c6
`define EVC_RET_RESYNC 12'h0c7
`define EVC_RET_NEAR 12'h0c8
`define EVC_RET_NEAR_MISP 12'h0c9
`define EVC_RET_TGT_MISP 12'h0ca
`define EVC_RET_FP 12'h0cb
`define EVC_IF_CLEAR 12'h0cd
`define EVC_IF_PENDING 12'h0ce

// ****************************************
// Unit-mask layouts and per-cycle limits
// ****************************************
`define UM_ITLB_MISS_VALID 8'h07
`define UM_IC_INVAL_VALID 8'h0f
`define UM_FP_CLASS_VALID 8'h07
`define UM_DISPATCH_VALID 8'h01
`define UM_NONE_VALID 8'h00
`define ICDE_SLOT_LIMIT 3
`define RETIRE_SLOT_LIMIT 6
`define MAX_INC 3'h4
`define UCODE_DISPATCH_INC 3'h4

`endif

/* File: rtl/perf_evt_pkg.sv */
// Types shared by the core event-source logic.
package perf_evt_pkg;

   typedef logic [2:0] inc_type;
   typedef logic [11:0] evt_code_type;
   typedef logic [7:0] umask_type;

   typedef struct packed {
      logic defined;
      inc_type inc;
   } slot_result_type;

   // Index of each conditioned event source.
   typedef enum {
      EV_IC_FETCH, EV_IC_MISS, EV_REFILL_L2, EV_REFILL_SYS, EV_ITLB_L2HIT,
      EV_ITLB_4K, EV_ITLB_2M, EV_ITLB_1G, EV_PROBE_RESTART, EV_FETCH_STALL,
      EV_RS_HIT, EV_RS_OVF, EV_VICTIM, EV_INV_CMC_MISS, EV_INV_CMC_HIT,
      EV_INV_SMC_MISS, EV_INV_SMC_HIT, EV_ITLB_RELOAD, EV_ITLB_ABORT, EV_DISPATCH,
      EV_RET_INSN, EV_RET_UOP, EV_RET_BR, EV_RET_BR_MISP, EV_RET_TAKEN,
      EV_RET_TAKEN_MISP, EV_RET_FAR, EV_RET_RESYNC, EV_RET_NEAR, EV_RET_NEAR_MISP,
      EV_RET_TGT_MISP, EV_FP_STACK, EV_FP_PACKED, EV_FP_VECTOR, EV_IF_CLEAR,
      EV_IF_PENDING, EV_NUM
   } ev_id_type;

   localparam int EV_COUNT = int'(EV_NUM);

endpackage

/* File: rtl/perf_weigh_if.sv */
// Carrier between the event stage and the per-cycle count weigher.
`timescale 1ns/100ps
interface perf_weigh_if;
   logic [2:0] raw;
   logic ucode;
   perf_evt_pkg::inc_type weighed;

   modport stage (output raw, output ucode, input weighed);
   modport weigh (input raw, input ucode, output weighed);
endinterface

/* File: rtl/perf_count_weigh.sv */
// Weighs a multi-event per-cycle count into the 0 to 4 increment range.
`timescale 1ns/100ps
`include "perf_evt_params.svh"
module perf_count_weigh (
   perf_weigh_if.weigh bus
);
   import perf_evt_pkg::*;

   // Microcode cycles with any dispatch are charged a full group; others saturate.
   always_comb begin
      if (bus.ucode && (bus.raw != 3'h0)) begin
         bus.weighed = `UCODE_DISPATCH_INC;
      end else if (bus.raw > `MAX_INC) begin
         bus.weighed = `MAX_INC;
      end else begin
         bus.weighed = bus.raw;
      end
   end
endmodule

/* File: rtl/core_perf_event_sources.sv */
// Fetch, decode and retire event sources feeding the performance counter slots.
// Function
// R1: Count cache fetches delivered to decoder.
// R2: Count demand and prefetch cache misses.
// R3: Count line refills from L2, system.
// R4: Count TLB second-level hits, reloads, aborts.
// R5: TLB double miss qualified by page size.
// R6: Count restarts from probes hitting stream.
// R7: Count every fetcher stall cycle.
// R8: Count returns served by non-empty stack.
// R9: Count calls overflowing stack, dropping oldest.
// R10: Count victims with changed predecode only.
// R11: Line invalidations qualified by probe kind.
// R12: Dispatch adds 0-4; microcode adds 4.
// R13: Count retired instructions; slots 0-5.
// R14: Count retired uops, 0-4 per cycle.
// R15: Count retired branches and taken branches.
// R16: Count mispredicted and taken mispredicted branches.
// R17: Count retired far control transfers.
// R18: Count retired resync branches.
// R19: Count near returns and mispredicted ones.
// R20: Count indirect branches with wrong target.
// R21: Floating-point classes by mask, one each.
// R22: Level while interrupts masked, or pending.
// R23: Undefined code or mask bit adds nothing.
`timescale 1ns/100ps
`include "perf_evt_params.svh"
module core_perf_event_sources #(
   parameter int NUM_SLOTS = 6
) (
   input wire logic clk_sys,
   input wire logic srst,
   // Fetch-side pipeline events, pulses or levels.
   input wire logic ic_fetch_to_decoder,
   input wire logic ic_demand_miss,
   input wire logic ic_prefetch_miss,
   input wire logic ic_refill_from_l2,
   input wire logic ic_refill_from_sys,
   input wire logic itlb_l1_miss_l2_hit,
   input wire logic itlb_l2_miss,
   input wire logic [1:0] itlb_miss_page_size,
   input wire logic itlb_reload_req,
   input wire logic itlb_reload_abort,
   input wire logic probe_hit_active_stream,
   input wire logic fetch_stalled,
   input wire logic ret_stack_pop,
   input wire logic ret_stack_empty,
   input wire logic call_stack_push,
   input wire logic ret_stack_full,
   input wire logic ic_evict,
   input wire logic ic_evict_predecode_changed,
   input wire logic ic_inval,
   input wire logic ic_inval_self_modify,
   input wire logic ic_inval_inflight_hit,
   // Decoder dispatch.
   input wire logic [2:0] dispatch_uops,
   input wire logic dispatch_from_microcode,
   // Retire-stage events.
   input wire logic [2:0] retire_insn_cnt,
   input wire logic [2:0] retire_uop_cnt,
   input wire logic retire_branch,
   input wire logic retire_taken,
   input wire logic retire_mispredict,
   input wire logic retire_far,
   input wire logic retire_resync,
   input wire logic retire_near_ret,
   input wire logic retire_near_ret_misp,
   input wire logic retire_indirect_tgt_misp,
   input wire logic retire_fp_stack,
   input wire logic retire_fp_packed,
   input wire logic retire_fp_vector,
   input wire logic int_flag,
   input wire logic int_pending,
   // Counter slot selection, one entry per perf_event_control_slot.
   input wire logic [NUM_SLOTS-1:0] slot_enable,
   input wire perf_evt_pkg::evt_code_type [NUM_SLOTS-1:0] slot_event_code,
   input wire perf_evt_pkg::umask_type [NUM_SLOTS-1:0] slot_unit_mask,
   output perf_evt_pkg::inc_type [NUM_SLOTS-1:0] slot_increment,
   output logic [NUM_SLOTS-1:0] slot_event_defined
);
   import perf_evt_pkg::*;

   // Unit-mask bit of the dispatch event that selects the uop count.
   localparam int decoder_uop_count_select = 0;
   // Encoding of the all_dispatched_ops choice within the dispatch mask.
   localparam umask_type all_dispatched_ops = 8'h00;

   // Page size codes reported with a double TLB miss.
   localparam logic [1:0] PAGE_4K = 2'h0;
   localparam logic [1:0] PAGE_2M = 2'h1;
   localparam logic [1:0] PAGE_1G = 2'h2;

   inc_type ev_nxt [EV_COUNT];
   inc_type ev_r [EV_COUNT];
   inc_type [NUM_SLOTS-1:0] inc_nxt;
   logic [NUM_SLOTS-1:0] defined_nxt;

   // ****************************************
   // Helper functions
   // ****************************************

   // Widens a single event flag to an increment.
   function automatic inc_type flag(input logic b);
      flag = {2'h0, b};
   endfunction

   // An event with no unit mask: any mask bit set is reserved and kills it.
   function automatic inc_type plain(input umask_type um, input inc_type v);
      plain = (um == `UM_NONE_VALID) ? v : 3'h0;
   endfunction

   // Sums the qualifier events whose mask bits are set, unless a reserved bit is set.
   function automatic inc_type mask_sum(input umask_type um, input umask_type valid,
                                        input inc_type b0, input inc_type b1,
                                        input inc_type b2, input inc_type b3);
      inc_type s;
      s = 3'h0;
      if ((um & ~valid) == 8'h00) begin
         if (um[0]) begin
            s = s + b0;
         end
         if (um[1]) begin
            s = s + b1;
         end
         if (um[2]) begin
            s = s + b2;
         end
         if (um[3]) begin
            s = s + b3;
         end
      end
      mask_sum = s;
   endfunction

   // Maps one slot's code and mask onto the conditioned events.
   function automatic slot_result_type decode_slot(input evt_code_type code, input umask_type um,
                                                   input int slot, input inc_type ev [EV_COUNT]);
      slot_result_type r;
      logic fetch_grp;
      r = '0;
      fetch_grp = 1'b1;
      r.defined = 1'b1;
      case (code)
         `EVC_IC_FETCH: r.inc = plain(um, ev[EV_IC_FETCH]);
         `EVC_IC_MISS: r.inc = plain(um, ev[EV_IC_MISS]);
         `EVC_IC_REFILL_L2: r.inc = plain(um, ev[EV_REFILL_L2]);
         `EVC_IC_REFILL_SYS: r.inc = plain(um, ev[EV_REFILL_SYS]);
         `EVC_ITLB_L2_HIT: r.inc = plain(um, ev[EV_ITLB_L2HIT]);
         `EVC_ITLB_RELOAD: r.inc = plain(um, ev[EV_ITLB_RELOAD]);
         `EVC_ITLB_ABORT: r.inc = plain(um, ev[EV_ITLB_ABORT]);
         // R5: page-size qualified miss
         `EVC_ITLB_MISS: begin
            r.inc = mask_sum(um, `UM_ITLB_MISS_VALID, ev[EV_ITLB_4K], ev[EV_ITLB_2M],
                             ev[EV_ITLB_1G], 3'h0);
         end
         `EVC_PROBE_RESTART: r.inc = plain(um, ev[EV_PROBE_RESTART]);
         `EVC_FETCH_STALL: r.inc = plain(um, ev[EV_FETCH_STALL]);
         `EVC_RS_HIT: r.inc = plain(um, ev[EV_RS_HIT]);
         `EVC_RS_OVERFLOW: r.inc = plain(um, ev[EV_RS_OVF]);
         `EVC_IC_VICTIM: r.inc = plain(um, ev[EV_VICTIM]);
         // R11: probe-kind qualified invalidations
         `EVC_IC_INVAL: begin
            r.inc = mask_sum(um, `UM_IC_INVAL_VALID, ev[EV_INV_CMC_MISS], ev[EV_INV_CMC_HIT],
                             ev[EV_INV_SMC_MISS], ev[EV_INV_SMC_HIT]);
         end
         // R12: dispatch count by mask
         `EVC_DISPATCH: begin
            if ((um & ~`UM_DISPATCH_VALID) != 8'h00) begin
               r.inc = 3'h0;
            end else if (um[decoder_uop_count_select] || (um == all_dispatched_ops)) begin
               r.inc = ev[EV_DISPATCH];
            end else begin
               r.inc = 3'h0;
            end
         end
         default: begin
            fetch_grp = 1'b0;
            case (code)
               `EVC_RET_INSN: r.inc = plain(um, ev[EV_RET_INSN]);
               `EVC_RET_UOP: r.inc = plain(um, ev[EV_RET_UOP]);
               `EVC_RET_BRANCH: r.inc = plain(um, ev[EV_RET_BR]);
               `EVC_RET_TAKEN: r.inc = plain(um, ev[EV_RET_TAKEN]);
               `EVC_RET_BR_MISP: r.inc = plain(um, ev[EV_RET_BR_MISP]);
               `EVC_RET_TAKEN_MISP: r.inc = plain(um, ev[EV_RET_TAKEN_MISP]);
               `EVC_RET_FAR: r.inc = plain(um, ev[EV_RET_FAR]);
               `EVC_RET_RESYNC: r.inc = plain(um, ev[EV_RET_RESYNC]);
               `EVC_RET_NEAR: r.inc = plain(um, ev[EV_RET_NEAR]);
               `EVC_RET_NEAR_MISP: r.inc = plain(um, ev[EV_RET_NEAR_MISP]);
               `EVC_RET_TGT_MISP: r.inc = plain(um, ev[EV_RET_TGT_MISP]);
               // R21: floating-point classes
               `EVC_RET_FP: begin
                  r.inc = mask_sum(um, `UM_FP_CLASS_VALID, ev[EV_FP_STACK], ev[EV_FP_PACKED],
                                   ev[EV_FP_VECTOR], 3'h0);
               end
               `EVC_IF_CLEAR: r.inc = plain(um, ev[EV_IF_CLEAR]);
               `EVC_IF_PENDING: r.inc = plain(um, ev[EV_IF_PENDING]);
               // R23: unknown code
               default: begin
                  r.defined = 1'b0;
                  r.inc = 3'h0;
               end
            endcase
         end
      endcase
      // R13: slot ranges per group
      if (fetch_grp && (slot >= `ICDE_SLOT_LIMIT)) begin
         r = '0;
      end else if (slot >= `RETIRE_SLOT_LIMIT) begin
         r = '0;
      end
      decode_slot = r;
   endfunction

   // ****************************************
   // Multi-event weighing
   // ****************************************

   perf_weigh_if disp_w ();
   perf_weigh_if uop_w ();
   perf_weigh_if insn_w ();

   // R12: microcode dispatch weighs as four
   assign disp_w.raw = dispatch_uops;
   assign disp_w.ucode = dispatch_from_microcode;
   // R14: retired uops saturate at four
   assign uop_w.raw = retire_uop_cnt;
   assign uop_w.ucode = 1'b0;
   assign insn_w.raw = retire_insn_cnt;
   assign insn_w.ucode = 1'b0;

   perf_count_weigh u_disp_weigh (
      .bus(disp_w.weigh)
   );

   perf_count_weigh u_uop_weigh (
      .bus(uop_w.weigh)
   );

   perf_count_weigh u_insn_weigh (
      .bus(insn_w.weigh)
   );

   // ****************************************
   // Event conditioning
   // ****************************************

   // Inputs come from logic on clk_sys, so they are taken without synchronisers.
   always_comb begin
      // R1: delivered fetches only
      ev_nxt[EV_IC_FETCH] = flag(ic_fetch_to_decoder);
      // R2: demand and prefetch may miss together
      ev_nxt[EV_IC_MISS] = flag(ic_demand_miss) + flag(ic_prefetch_miss);
      // R3: one line per refill
      ev_nxt[EV_REFILL_L2] = flag(ic_refill_from_l2);
      ev_nxt[EV_REFILL_SYS] = flag(ic_refill_from_sys);
      // R4: second-level hit and reloads
      ev_nxt[EV_ITLB_L2HIT] = flag(itlb_l1_miss_l2_hit);
      ev_nxt[EV_ITLB_RELOAD] = flag(itlb_reload_req);
      ev_nxt[EV_ITLB_ABORT] = flag(itlb_reload_abort);
      // R5: split double miss by page size
      ev_nxt[EV_ITLB_4K] = flag(itlb_l2_miss && (itlb_miss_page_size == PAGE_4K));
      ev_nxt[EV_ITLB_2M] = flag(itlb_l2_miss && (itlb_miss_page_size == PAGE_2M));
      ev_nxt[EV_ITLB_1G] = flag(itlb_l2_miss && (itlb_miss_page_size == PAGE_1G));
      // R6: probe restart pulse
      ev_nxt[EV_PROBE_RESTART] = flag(probe_hit_active_stream);
      // R7: stall level, any cause
      ev_nxt[EV_FETCH_STALL] = flag(fetch_stalled);
      // R8: pop from non-empty stack
      ev_nxt[EV_RS_HIT] = flag(ret_stack_pop && !ret_stack_empty);
      // R9: push onto full stack
      ev_nxt[EV_RS_OVF] = flag(call_stack_push && ret_stack_full);
      // R10: only predecode-changed victims
      ev_nxt[EV_VICTIM] = flag(ic_evict && ic_evict_predecode_changed);
      // R11: split invalidations by kind
      ev_nxt[EV_INV_CMC_MISS] = flag(ic_inval && !ic_inval_self_modify && !ic_inval_inflight_hit);
      ev_nxt[EV_INV_CMC_HIT] = flag(ic_inval && !ic_inval_self_modify && ic_inval_inflight_hit);
      ev_nxt[EV_INV_SMC_MISS] = flag(ic_inval && ic_inval_self_modify && !ic_inval_inflight_hit);
      ev_nxt[EV_INV_SMC_HIT] = flag(ic_inval && ic_inval_self_modify && ic_inval_inflight_hit);
      // R12: weighed dispatch
      ev_nxt[EV_DISPATCH] = disp_w.weighed;
      // R13: retired instructions, capped
      ev_nxt[EV_RET_INSN] = insn_w.weighed;
      // R14: retired uops, capped
      ev_nxt[EV_RET_UOP] = uop_w.weighed;
      // R15: far transfers are branches, always taken
      ev_nxt[EV_RET_BR] = flag(retire_branch || retire_far);
      ev_nxt[EV_RET_TAKEN] = flag(retire_taken || retire_far);
      // R16: unpredicted far transfers count as mispredicted branches, not as taken mispredicted
      ev_nxt[EV_RET_BR_MISP] = flag((retire_branch && retire_mispredict) || retire_far);
      ev_nxt[EV_RET_TAKEN_MISP] = flag(retire_branch && retire_taken && retire_mispredict);
      // R17: far transfers
      ev_nxt[EV_RET_FAR] = flag(retire_far);
      // R18: resyncs
      ev_nxt[EV_RET_RESYNC] = flag(retire_resync);
      // R19: near returns and their mispredicts
      ev_nxt[EV_RET_NEAR] = flag(retire_near_ret);
      ev_nxt[EV_RET_NEAR_MISP] = flag(retire_near_ret && retire_near_ret_misp);
      // R20: indirect target mismatch
      ev_nxt[EV_RET_TGT_MISP] = flag(retire_indirect_tgt_misp);
      // R21: one per complete instruction per class
      ev_nxt[EV_FP_STACK] = flag(retire_fp_stack);
      ev_nxt[EV_FP_PACKED] = flag(retire_fp_packed);
      ev_nxt[EV_FP_VECTOR] = flag(retire_fp_vector);
      // R22: levels, so an edge counter sees one rise per masked interval
      ev_nxt[EV_IF_CLEAR] = flag(!int_flag);
      ev_nxt[EV_IF_PENDING] = flag(!int_flag && int_pending);
   end

   // One register stage aligns all sources before selection.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         for (int i = 0; i < EV_COUNT; i++) begin
            ev_r[i] <= 3'h0;
         end
      end else begin
         ev_r <= ev_nxt;
      end
   end

   // ****************************************
   // Slot selection
   // ****************************************

   // A disabled slot still reports whether its code is known, but adds nothing.
   always_comb begin
      slot_result_type res;
      res = '0;
      for (int s = 0; s < NUM_SLOTS; s++) begin
         res = decode_slot(slot_event_code[s], slot_unit_mask[s], s, ev_r);
         defined_nxt[s] = res.defined;
         // R23: disabled or undefined adds nothing
         inc_nxt[s] = (slot_enable[s] && res.defined) ? res.inc : 3'h0;
      end
   end

   // Increments are registered so the counters see clean per-cycle values.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         slot_increment <= '0;
         slot_event_defined <= '0;
      end else begin
         slot_increment <= inc_nxt;
         slot_event_defined <= defined_nxt;
      end
   end

endmodule

/* File: tb/perf_evt_checker_assertions.sv */
// Concurrent checks on the ports of the event-source block.
`timescale 1ns/100ps
module perf_evt_checker #(
   parameter int NUM_SLOTS = 6
) (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic ic_fetch_to_decoder,
   input wire logic fetch_stalled,
   input wire logic retire_far,
   input wire logic [2:0] retire_uop_cnt,
   input wire logic int_flag,
   input wire logic [NUM_SLOTS-1:0] slot_enable,
   input wire perf_evt_pkg::evt_code_type [NUM_SLOTS-1:0] slot_event_code,
   input wire perf_evt_pkg::umask_type [NUM_SLOTS-1:0] slot_unit_mask,
   input wire perf_evt_pkg::inc_type [NUM_SLOTS-1:0] slot_increment,
   input wire logic [NUM_SLOTS-1:0] slot_event_defined
);
   import perf_evt_pkg::*;
   // ****************************************
   // Slot 0 selection and checks
   // ****************************************
   // Slot 0 code when enabled with a clear mask, else an unused code.
   evt_code_type c0;
   assign c0 = (slot_enable[0] && slot_unit_mask[0] == 8'h00) ? slot_event_code[0] : 12'hfff;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);
   // Events pass two register stages, so both edges must show the code.
   fetch_count_a: assert property (c0 == 12'h080 && ic_fetch_to_decoder ##1 c0 == 12'h080
      |=> slot_increment[0] == 3'h1) else $error("Fetch access not counted once.");
   stall_count_a: assert property (c0 == 12'h087 && fetch_stalled ##1 c0 == 12'h087
      |=> slot_increment[0] == 3'h1) else $error("Stall cycle not counted.");
   slot_limit_a: assert property (slot_event_code[3] == 12'h080
      |=> slot_increment[3] == 3'h0 && !slot_event_defined[3]) else $error("Fetch event on slot 3.");
   retire_slot_a: assert property (slot_event_code[5] == 12'h0c0 && slot_unit_mask[5] == 8'h00
      |=> slot_event_defined[5]) else $error("Retire event refused on slot 5.");
   inc_range_a: assert property (slot_increment[0] <= 3'h4) else $error("Increment above four.");
   uop_count_a: assert property (c0 == 12'h0c1 ##1 c0 == 12'h0c1 |=> slot_increment[0] ==
      (($past(retire_uop_cnt, 2) > 3'h4) ? 3'h4 : $past(retire_uop_cnt, 2))) else $error("Uop weight wrong.");
   far_taken_a: assert property (c0 == 12'h0c4 && retire_far ##1 c0 == 12'h0c4
      |=> slot_increment[0] == 3'h1) else $error("Far transfer not taken branch.");
   if_clear_a: assert property (c0 == 12'h0cd ##1 c0 == 12'h0cd
      |=> slot_increment[0] == {2'b00, !$past(int_flag, 2)}) else $error("Masked cycle level wrong.");
   fp_reserved_a: assert property (slot_enable[0] && slot_event_code[0] == 12'h0cb
      && slot_unit_mask[0][7:3] != 5'h00 |=> slot_increment[0] == 3'h0) else $error("Reserved class counted.");
   undef_code_a: assert property (slot_event_code[0] == 12'h0cc
      |=> slot_increment[0] == 3'h0) else $error("Undefined code counted.");
endmodule
bind core_perf_event_sources perf_evt_checker #(.NUM_SLOTS(NUM_SLOTS)) perf_evt_checker_inst (
   .clk_sys(clk_sys), .srst(srst), .ic_fetch_to_decoder(ic_fetch_to_decoder), .fetch_stalled(fetch_stalled),
   .retire_far(retire_far), .retire_uop_cnt(retire_uop_cnt), .int_flag(int_flag), .slot_enable(slot_enable),
   .slot_event_code(slot_event_code), .slot_unit_mask(slot_unit_mask), .slot_increment(slot_increment),
   .slot_event_defined(slot_event_defined));

/* File: tb/pipe_model.sv */
// Behavioural fetch, decode and retire stages presenting event lines to the block.
`timescale 1ns/100ps
module pipe_model (
   input wire logic clk_sys,
   input wire logic [31:0] pulse_req,
   input wire logic [12:0] level_req,
   output logic [31:0] ev = 32'h0,
   output logic [12:0] lv = 13'h0800
);
   // Requests appear one edge later, as from a stage register, so no edge race.
   always @(posedge clk_sys) begin
      ev <= pulse_req;
      lv <= level_req;
   end
endmodule

/* File: tb/core_perf_event_sources_tb.sv */
// Self-checking bench for the core event sources.
`timescale 1ns/100ps
module core_perf_event_sources_tb;
   import perf_evt_pkg::*;
   localparam logic [12:0] L0 = 13'h0800;
   logic clk_sys;
   logic srst;
   logic [31:0] preq;
   logic [12:0] lreq;
   logic [31:0] ev;
   logic [12:0] lv;
   logic [5:0] en;
   evt_code_type [5:0] code;
   umask_type [5:0] mask;
   inc_type [5:0] slot_increment;
   logic [5:0] slot_event_defined;
   int miscompares;
   int cmp_count;
   // ****************************************
   // Block, partner and clock
   // ****************************************
   // Level bits: page size, dispatch uops, retired insns, retired uops, flag, pending.
   core_perf_event_sources #(.NUM_SLOTS(6)) core_perf_event_sources_inst (.clk_sys(clk_sys), .srst(srst),
      .ic_fetch_to_decoder(ev[0]), .ic_demand_miss(ev[1]), .ic_prefetch_miss(ev[2]), .ic_refill_from_l2(ev[3]),
      .ic_refill_from_sys(ev[4]), .itlb_l1_miss_l2_hit(ev[5]), .itlb_l2_miss(ev[6]), .itlb_miss_page_size(lv[1:0]),
      .itlb_reload_req(ev[7]), .itlb_reload_abort(ev[8]), .probe_hit_active_stream(ev[9]),
      .fetch_stalled(ev[10]), .ret_stack_pop(ev[11]), .ret_stack_empty(ev[12]), .call_stack_push(ev[13]),
      .ret_stack_full(ev[14]), .ic_evict(ev[15]), .ic_evict_predecode_changed(ev[16]), .ic_inval(ev[17]),
      .ic_inval_self_modify(ev[18]), .ic_inval_inflight_hit(ev[19]), .dispatch_uops(lv[4:2]),
      .dispatch_from_microcode(ev[20]), .retire_insn_cnt(lv[7:5]), .retire_uop_cnt(lv[10:8]),
      .retire_branch(ev[21]), .retire_taken(ev[22]), .retire_mispredict(ev[23]), .retire_far(ev[24]),
      .retire_resync(ev[25]), .retire_near_ret(ev[26]), .retire_near_ret_misp(ev[27]),
      .retire_indirect_tgt_misp(ev[28]), .retire_fp_stack(ev[29]), .retire_fp_packed(ev[30]),
      .retire_fp_vector(ev[31]), .int_flag(lv[11]), .int_pending(lv[12]), .slot_enable(en),
      .slot_event_code(code), .slot_unit_mask(mask), .slot_increment(slot_increment),
      .slot_event_defined(slot_event_defined));
   pipe_model pipe_model_inst (.clk_sys(clk_sys), .pulse_req(preq), .level_req(lreq), .ev(ev), .lv(lv));
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   // ****************************************
   // Compare, drive and scenario tasks
   // ****************************************
   task automatic chk_inc(input int s, input evt_code_type c, input inc_type e, input inc_type g);
      cmp_count++;
      if (g !== e) begin
         miscompares++;
         $display("FAIL slot_increment[%0d] code %h expected %h seen %h", s, c, e, g);
      end
   endtask
   task automatic chk_def(input int s, input evt_code_type c, input logic e, input logic g);
      cmp_count++;
      if (g !== e) begin
         miscompares++;
         $display("FAIL slot_event_defined[%0d] code %h expected %b seen %b", s, c, e, g);
      end
   endtask
   // One event cycle on all slots; slot 1 stays disabled. dk: 0 unknown, 1 known, 2 not judged.
   task automatic run(input evt_code_type c, input umask_type m, input logic [31:0] p, input logic [12:0] l,
      input inc_type e, input int dk);
      int lim;
      lim = (c < 12'h0c0 || c == 12'h186) ? 3 : 6;
      code = {6{c}};
      mask = {6{m}};
      preq = p;
      lreq = l;
      @(posedge clk_sys);
      #1;
      preq = 32'h0;
      lreq = L0;
      repeat (2) @(posedge clk_sys);
      #1;
      for (int s = 0; s < 6; s++) begin
         chk_inc(s, c, (s < lim && s != 1) ? e : 3'h0, slot_increment[s]);
         if (dk < 2) chk_def(s, c, dk == 1 && s < lim, slot_event_defined[s]);
      end
      @(posedge clk_sys);
      #1;
      for (int s = 0; s < 6; s++) chk_inc(s, c, 3'h0, slot_increment[s]);
   endtask
   task automatic fetch_events;
      run(12'h080, 8'h00, 32'h1, L0, 3'h1, 1);
      run(12'h081, 8'h00, 32'h6, L0, 3'h2, 1);
      run(12'h082, 8'h00, 32'h8, L0, 3'h1, 1);
      run(12'h083, 8'h00, 32'h10, L0, 3'h1, 1);
      run(12'h084, 8'h00, 32'h20, L0, 3'h1, 1);
      run(12'h099, 8'h00, 32'h80, L0, 3'h1, 1);
      run(12'h09a, 8'h00, 32'h100, L0, 3'h1, 1);
      run(12'h086, 8'h00, 32'h200, L0, 3'h1, 1);
      run(12'h087, 8'h00, 32'h400, L0, 3'h1, 1);
      run(12'h088, 8'h00, 32'h800, L0, 3'h1, 1);
      run(12'h088, 8'h00, 32'h1800, L0, 3'h0, 1);
      run(12'h089, 8'h00, 32'h6000, L0, 3'h1, 1);
      run(12'h08b, 8'h00, 32'h8000, L0, 3'h0, 1);
      run(12'h08b, 8'h00, 32'h18000, L0, 3'h1, 1);
   endtask
   task automatic masked_events;
      run(12'h085, 8'h01, 32'h40, L0, 3'h1, 1);
      run(12'h085, 8'h02, 32'h40, L0, 3'h0, 1);
      run(12'h085, 8'h04, 32'h40, 13'h0802, 3'h1, 1);
      run(12'h08c, 8'h01, 32'h20000, L0, 3'h1, 1);
      run(12'h08c, 8'h08, 32'he0000, L0, 3'h1, 1);
      run(12'h08c, 8'h10, 32'h20000, L0, 3'h0, 2);
      run(12'h0cb, 8'h07, 32'he0000000, L0, 3'h3, 1);
      run(12'h0cb, 8'h02, 32'h20000000, L0, 3'h0, 1);
      run(12'h0cb, 8'h08, 32'h20000000, L0, 3'h0, 2);
   endtask
   task automatic dispatch_retire;
      run(12'h186, 8'h00, 32'h0, 13'h080c, 3'h3, 1);
      run(12'h186, 8'h01, 32'h0, 13'h081c, 3'h4, 1);
      run(12'h186, 8'h00, 32'h100000, 13'h0804, 3'h4, 1);
      run(12'h0c0, 8'h00, 32'h0, 13'h0860, 3'h3, 1);
      run(12'h0c1, 8'h00, 32'h0, 13'h0c00, 3'h4, 1);
   endtask
   task automatic branch_events;
      run(12'h0c2, 8'h00, 32'h200000, L0, 3'h1, 1);
      run(12'h0c4, 8'h00, 32'h1000000, L0, 3'h1, 1);
      run(12'h0c3, 8'h00, 32'h1000000, L0, 3'h1, 1);
      run(12'h0c5, 8'h00, 32'ha00000, L0, 3'h0, 1);
      run(12'h0c5, 8'h00, 32'he00000, L0, 3'h1, 1);
      run(12'h0c6, 8'h00, 32'h1000000, L0, 3'h1, 1);
      run(12'h0c7, 8'h00, 32'h2000000, L0, 3'h1, 1);
      run(12'h0c8, 8'h00, 32'h4000000, L0, 3'h1, 1);
      run(12'h0c9, 8'h00, 32'h4000000, L0, 3'h0, 1);
      run(12'h0c9, 8'h00, 32'hc000000, L0, 3'h1, 1);
      run(12'h0ca, 8'h00, 32'h10000000, L0, 3'h1, 1);
   endtask
   task automatic int_and_undefined;
      run(12'h0cd, 8'h00, 32'h0, 13'h0000, 3'h1, 1);
      run(12'h0ce, 8'h00, 32'h0, 13'h1000, 3'h1, 1);
      run(12'h0cc, 8'h00, 32'hffffffff, L0, 3'h0, 0);
      run(12'h080, 8'h01, 32'h1, L0, 3'h0, 2);
   endtask
   task automatic results;
      if (miscompares == 0 && cmp_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // Reset for two edges, then every scenario in turn.
   initial begin
      srst = 1'b1;
      preq = 32'h0;
      lreq = L0;
      en = 6'b111101;
      code = '0;
      mask = '0;
      miscompares = 0;
      cmp_count = 0;
      repeat (2) @(posedge clk_sys);
      #1;
      srst = 1'b0;
      fetch_events();
      masked_events();
      dispatch_retire();
      branch_events();
      int_and_undefined();
      results();
   end
   // A hang costs a mismatch; the scenarios need well under a thousand cycles.
   initial begin
      repeat (5000) @(posedge clk_sys);
      miscompares++;
      results();
   end
endmodule
